// file: design/pwp_map.svh
// Offsets, field positions and reset values of the write protect bridge
//
// Notes on behaviour
// - One guard per bridge; each attached peripheral has its own protect bit.
// - Guard keeps working in sleep while its selected clock keeps running.
// - Debugger writes ignore protection and reach the peripheral.
// - Writing one to a clear bit drops that protect bit in both views.
// - Writing one to a set bit raises that protect bit in both views.
// - Set and clear views read back the same protect vector.
// - Protected non-debug write is dropped and answered with an error.
// - Setting an already set protect bit answers with an error.
// - Clearing an already clear protect bit answers with an error.
// - After reset guard clocks one and two run, guard clock three stops.
// - Bridge is a bus slave forwarding accesses onto the peripheral bus.
// - Bridge supports wait states, errors, protection signals and byte strobes.
// - Address and data phases of the peripheral bus share one cycle.
// - Byte and halfword strobes also qualify reads.
// - Writing zero to a set or clear bit changes nothing.
// - Protect registers accept byte, halfword and word accesses.
`ifndef PWP_MAP_SVH
`define PWP_MAP_SVH

`define PWP_OFF_CLR       4'h0
`define PWP_OFF_SET       4'h4
`define PWP_OFF_CLKEN     4'h8
`define PWP_OFF_FAULT     4'hC
`define PWP_PROT_RESET    32'h0000_0000
`define PWP_CLKEN_RESET   3'h3
`define PWP_FAULT_VLD_BIT 31
`define PWP_DEBUG_MASTER  4'h1
`define PWP_SLOT_LSB      10

`endif

// file: design/pwp_pkg.sv
// Types shared by the write protect bridge modules
package pwp_pkg;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_DATA   = 5'b00010,
    ST_ACCESS = 5'b00100,
    ST_ERR1   = 5'b01000,
    ST_ERR2   = 5'b10000
  } pwp_state_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [3:0]  hprot;
    logic [3:0]  hmaster;
    logic        hready;
  } pwp_ahb_req_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [2:0]  pprot;
  } pwp_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pwp_apb_rsp_t;

endpackage : pwp_pkg

// file: design/pwp_guard_bits.sv
// Protect bit vector with set and clear strobes and double-operation check
`timescale 1ns/10ps
`default_nettype none
`include "pwp_map.svh"
module pwp_guard_bits #(
  parameter int N_PERIPH = 32
) (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                set_stb,
  input  wire logic                clr_stb,
  input  wire logic [N_PERIPH-1:0] mask,
  output logic      [N_PERIPH-1:0] prot,
  output logic                     dbl_err
);
  import pwp_pkg::*;

  localparam logic [31:0] PROT_RST = `PWP_PROT_RESET;

  initial begin
    if (N_PERIPH < 1 || N_PERIPH > 32) begin
      $error("pwp_guard_bits: N_PERIPH must lie in 1..32");
    end
  end

  // ----------------------------------------------------------------
  // One flop per peripheral
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N_PERIPH; g++) begin : g_bit
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          prot[g] <= PROT_RST[g];
        end else if (set_stb && mask[g]) begin
          prot[g] <= 1'b1;
        end else if (clr_stb && mask[g]) begin
          prot[g] <= 1'b0;
        end
      end
    end
  endgenerate
  // Zero bits of the mask leave their flop alone

  // Double protect or double unprotect of any selected bit
  always_comb begin
    dbl_err = (set_stb && |(mask & prot)) ||
              (clr_stb && |(mask & ~prot));
  end

endmodule : pwp_guard_bits
`default_nettype wire

// file: design/pwp_bridge.sv
// Host-to-peripheral bus bridge with per-peripheral write protection
`timescale 1ns/10ps
`default_nettype none
`include "pwp_map.svh"
module pwp_bridge #(
  parameter int N_PERIPH = 32,
  parameter int SLOT_LSB = `PWP_SLOT_LSB
) (
  input  wire logic                  CLK,
  input  wire logic                  RST_B,
  // Host side
  input  wire pwp_pkg::pwp_ahb_req_t AHB_REQ,
  input  wire logic [31:0]           HWDATA,
  output logic                       HREADYOUT,
  output logic                       HRESP,
  output logic [31:0]                HRDATA,
  // Peripheral side
  output pwp_pkg::pwp_apb_req_t      APB_REQ,
  input  wire pwp_pkg::pwp_apb_rsp_t APB_RSP,
  // Guard register port
  input  wire logic [3:0]            REG_ADDR,
  input  wire logic [31:0]           REG_WDATA,
  input  wire logic [3:0]            REG_BE,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  output logic [31:0]                REG_RDATA,
  output logic                       REG_ERR,
  // Guard bus clock enables, bit 2 is the third guard's clock
  output logic [2:0]                 GUARD_CLK_EN
);
  import pwp_pkg::*;

  localparam int IDX_W = (N_PERIPH > 1) ? $clog2(N_PERIPH) : 1;
  localparam logic [3:0] DBG_ID = `PWP_DEBUG_MASTER;

  initial begin
    if (N_PERIPH < 1 || N_PERIPH > 32) begin
      $error("pwp_bridge: N_PERIPH must lie in 1..32");
    end
    if (SLOT_LSB < 2 || SLOT_LSB + IDX_W > 32) begin
      $error("pwp_bridge: SLOT_LSB does not fit the address");
    end
  end

  // ----------------------------------------------------------------
  // Strobe generation
  // ----------------------------------------------------------------
  function automatic logic [3:0] strb_of(input logic [2:0] sz,
                                         input logic [1:0] a);
    case (sz)
      3'h0:    strb_of = 4'h1 << a;
      3'h1:    strb_of = a[1] ? 4'hC : 4'h3;
      default: strb_of = 4'hF;
    endcase
  endfunction : strb_of

  // ----------------------------------------------------------------
  // Captured address phase
  // ----------------------------------------------------------------
  pwp_state_t              state;
  logic [31:0]             addr_q;
  logic                    write_q;
  logic [2:0]              size_q;
  logic [3:0]              hprot_q;
  logic                    dbg_q;
  logic [IDX_W-1:0]        idx_q;
  logic [N_PERIPH-1:0]     prot;
  logic                    take;
  logic                    blocked;
  logic [N_PERIPH-1:0]     prot_idx;

  // A new transfer is taken wherever HREADYOUT stands high
  always_comb begin
    take = (state == ST_IDLE || state == ST_ERR2) && AHB_REQ.hsel &&
           AHB_REQ.htrans[1] && AHB_REQ.hready;
  end

  always_comb begin
    prot_idx = prot >> idx_q;
    blocked  = write_q && prot_idx[0] && !dbg_q;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      addr_q  <= 32'h0000_0000;
      write_q <= 1'b0;
      size_q  <= 3'h0;
      hprot_q <= 4'h0;
      dbg_q   <= 1'b0;
      idx_q   <= '0;
    end else if (take) begin
      addr_q  <= AHB_REQ.haddr;
      write_q <= AHB_REQ.hwrite;
      size_q  <= AHB_REQ.hsize;
      hprot_q <= AHB_REQ.hprot;
      dbg_q   <= (AHB_REQ.hmaster == DBG_ID);
      idx_q   <= AHB_REQ.haddr[SLOT_LSB +: IDX_W];
    end
  end

  // ----------------------------------------------------------------
  // Bridge state machine
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE, ST_ERR2: begin
          state <= take ? ST_DATA : ST_IDLE;
        end
        ST_DATA: begin
          state <= blocked ? ST_ERR1 : ST_ACCESS;
        end
        ST_ACCESS: begin
          if (APB_RSP.pready) begin
            state <= APB_RSP.pslverr ? ST_ERR1 : ST_IDLE;
          end
        end
        ST_ERR1: begin
          state <= ST_ERR2;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Host response; errors take the two-cycle form so the master can
  // cancel whatever it has queued behind the failed transfer
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      HRDATA    <= 32'h0000_0000;
    end else begin
      case (state)
        ST_IDLE, ST_ERR2: begin
          HREADYOUT <= !take;
          HRESP     <= 1'b0;
        end
        ST_DATA: begin
          HREADYOUT <= 1'b0;
          HRESP     <= blocked;
        end
        ST_ACCESS: begin
          if (APB_RSP.pready) begin
            HREADYOUT <= !APB_RSP.pslverr;
            HRESP     <= APB_RSP.pslverr;
            HRDATA    <= APB_RSP.prdata;
          end
        end
        ST_ERR1: begin
          HREADYOUT <= 1'b1;
          HRESP     <= 1'b1;
        end
        default: begin
          HREADYOUT <= 1'b1;
          HRESP     <= 1'b0;
        end
      endcase
    end
  end

  // Peripheral request; select and enable rise together, so there is
  // no separate setup cycle and every access is one cycle shorter
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      APB_REQ <= '0;
    end else if (state == ST_DATA && !blocked) begin
      APB_REQ.psel    <= 1'b1;
      APB_REQ.penable <= 1'b1;
      APB_REQ.pwrite  <= write_q;
      APB_REQ.paddr   <= addr_q;
      APB_REQ.pwdata  <= write_q ? HWDATA : 32'h0000_0000;
      APB_REQ.pstrb   <= strb_of(size_q, addr_q[1:0]);
      APB_REQ.pprot   <= {~hprot_q[0], 1'b0, hprot_q[1]};
    end else if (state == ST_ACCESS && APB_RSP.pready) begin
      APB_REQ.psel    <= 1'b0;
      APB_REQ.penable <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Guard registers
  // ----------------------------------------------------------------
  logic [31:0]         be_mask;
  logic [31:0]         wmask;
  logic                set_stb;
  logic                clr_stb;
  logic                dbl_err;
  logic [31:0]         rd_prot;
  logic [31:0]         fault;
  logic [31:0]         next_rdata;

  always_comb begin
    be_mask = {{8{REG_BE[3]}}, {8{REG_BE[2]}},
               {8{REG_BE[1]}}, {8{REG_BE[0]}}};
    wmask   = REG_WDATA & be_mask;
    set_stb = REG_WR && REG_ADDR == `PWP_OFF_SET;
    clr_stb = REG_WR && REG_ADDR == `PWP_OFF_CLR;
    rd_prot = 32'h0000_0000;
    rd_prot[N_PERIPH-1:0] = prot;
  end

  pwp_guard_bits #(
    .N_PERIPH (N_PERIPH)
  ) u_guard (
    .clk      (CLK),
    .rst_b    (RST_B),
    .set_stb  (set_stb),
    .clr_stb  (clr_stb),
    .mask     (wmask[N_PERIPH-1:0]),
    .prot     (prot),
    .dbl_err  (dbl_err)
  );

  // Guard clocks are left as they are in sleep; the protect bits live
  // on CLK alone and nothing else stops them
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      GUARD_CLK_EN <= `PWP_CLKEN_RESET;
    end else if (REG_WR && REG_ADDR == `PWP_OFF_CLKEN && REG_BE[0]) begin
      GUARD_CLK_EN <= REG_WDATA[2:0];
    end
  end

  // Last blocked peripheral; a new block wins over a same-cycle clear
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      fault <= 32'h0000_0000;
    end else if (state == ST_DATA && blocked) begin
      fault <= 32'h0000_0000;
      fault[`PWP_FAULT_VLD_BIT] <= 1'b1;
      fault[IDX_W-1:0] <= idx_q;
    end else if (REG_WR && REG_ADDR == `PWP_OFF_FAULT && REG_BE[3] &&
                 REG_WDATA[`PWP_FAULT_VLD_BIT]) begin
      fault[`PWP_FAULT_VLD_BIT] <= 1'b0;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (REG_RD) begin
      case (REG_ADDR)
        `PWP_OFF_CLR, `PWP_OFF_SET: next_rdata = rd_prot;
        `PWP_OFF_CLKEN: next_rdata = {29'h0000_0000, GUARD_CLK_EN};
        `PWP_OFF_FAULT: next_rdata = fault;
        default:        next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      REG_RDATA <= 32'h0000_0000;
      REG_ERR   <= 1'b0;
    end else begin
      REG_RDATA <= next_rdata;
      REG_ERR   <= dbl_err;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence s_err_two_cycle;
    (HRESP && !HREADYOUT) ##1 (HRESP && HREADYOUT);
  endsequence

  sequence s_blocked_data;
    state == ST_DATA && blocked;
  endsequence

  a_blocked_write_err: assert property (
    s_blocked_data |=> !APB_REQ.psel ##0 s_err_two_cycle)
    else $error("protected write was not refused");

  a_debug_write_pass: assert property (
    (state == ST_DATA && write_q && dbg_q) |=>
      (APB_REQ.psel && APB_REQ.pwrite))
    else $error("debugger write did not reach peripheral");

  a_merged_phase: assert property (
    $rose(APB_REQ.psel) |-> APB_REQ.penable)
    else $error("select rose without enable");

  a_read_strobes: assert property (
    (state == ST_DATA && !write_q) |=>
      (APB_REQ.psel && APB_REQ.pstrb == strb_of(size_q, addr_q[1:0])))
    else $error("read strobes wrong");

  a_slverr_relay: assert property (
    (state == ST_ACCESS && APB_RSP.pready && APB_RSP.pslverr) |=>
      s_err_two_cycle)
    else $error("peripheral error not relayed");

  a_set_bit0: assert property (
    (set_stb && wmask[0]) |=> prot[0])
    else $error("set view did not raise bit");

  a_clr_bit0: assert property (
    (clr_stb && wmask[0]) |=> !prot[0])
    else $error("clear view did not drop bit");

  a_zero_noop: assert property (
    (REG_WR && wmask == 32'h0000_0000) |=> $stable(prot))
    else $error("zero write changed protect bits");

  a_views_equal: assert property (
    (REG_RD && (REG_ADDR == `PWP_OFF_SET || REG_ADDR == `PWP_OFF_CLR))
      |=> REG_RDATA == $past(rd_prot))
    else $error("protect views disagree");

  a_double_set: assert property (
    (set_stb && |(wmask[N_PERIPH-1:0] & prot)) |=> REG_ERR)
    else $error("double protect not flagged");

  a_double_clr: assert property (
    (clr_stb && |(wmask[N_PERIPH-1:0] & ~prot)) |=> REG_ERR)
    else $error("double unprotect not flagged");

  a_clken_held: assert property (
    !(REG_WR && REG_ADDR == `PWP_OFF_CLKEN) |=> $stable(GUARD_CLK_EN))
    else $error("guard clock enables moved");

  a_fault_record: assert property (
    s_blocked_data |=> (fault[`PWP_FAULT_VLD_BIT] &&
      fault[IDX_W-1:0] == $past(idx_q)))
    else $error("blocked peripheral not recorded");

  a_reg_err_quiet: assert property (
    (REG_WR && !dbl_err) |=> !REG_ERR)
    else $error("spurious double operation error");

  a_word_strobes: assert property (
    (state == ST_DATA && !blocked && size_q == 3'h2) |=>
      APB_REQ.pstrb == 4'hF)
    else $error("word transfer strobes wrong");

endmodule : pwp_bridge
`default_nettype wire

// file: test/pwp_periph_model.sv
// Peripheral model answering the bridge on its peripheral bus
`timescale 1ns/10ps
`default_nettype none
module pwp_periph_model (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire pwp_pkg::pwp_apb_req_t req,
  input  wire logic [1:0]            wait_cyc,
  input  wire logic                  err_en,
  output var  pwp_pkg::pwp_apb_rsp_t rsp
);
  import pwp_pkg::*;
  logic [31:0] mem [32];
  logic [31:0] last;
  logic [31:0] lane;
  logic [1:0]  cnt;
  logic        hit;
  logic [4:0]  idx;

  assign idx  = req.paddr[14:10];
  assign lane = {{8{req.pstrb[3]}}, {8{req.pstrb[2]}},
                 {8{req.pstrb[1]}}, {8{req.pstrb[0]}}};
  // Answer after a chosen number of wait cycles
  assign hit  = req.psel && req.penable && (cnt == wait_cyc);

  always_comb begin
    rsp.pready  = hit;
    rsp.pslverr = hit && err_en;
    // Only strobed lanes carry data; idle bus shows a changing pattern
    rsp.prdata  = (hit && !req.pwrite) ? (mem[idx] & lane) : ~last;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt  <= 2'h0;
      last <= 32'h0;
    end else begin
      cnt  <= (req.psel && req.penable && !hit) ? cnt + 2'h1 : 2'h0;
      last <= rsp.prdata;
      if (hit && req.pwrite && !err_en) begin
        mem[idx] <= (mem[idx] & ~lane) | (req.pwdata & lane);
      end
    end
  end
endmodule : pwp_periph_model
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the write protect bridge
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
  miscompares++; $display("FAIL %s expected %h seen %h", nm, exp, got); end end
module tb;
  import pwp_pkg::*;
  logic         CLK = 1'b0;
  logic         RST_B = 1'b0;
  pwp_ahb_req_t AHB_REQ = '0;
  pwp_apb_req_t APB_REQ;
  pwp_apb_rsp_t APB_RSP;
  logic [31:0]  HWDATA = 32'h0;
  logic [31:0]  HRDATA;
  logic         HREADYOUT;
  logic         HRESP;
  logic [3:0]   REG_ADDR = 4'h0;
  logic [31:0]  REG_WDATA = 32'h0;
  logic [3:0]   REG_BE = 4'h0;
  logic         REG_WR = 1'b0;
  logic         REG_RD = 1'b0;
  logic [31:0]  REG_RDATA;
  logic         REG_ERR;
  logic [2:0]   GUARD_CLK_EN;
  logic [1:0]   wait_cyc = 2'h0;
  logic         err_en = 1'b0;
  logic [64:0]  hq[$];
  logic [64:0]  rq[$];
  logic [31:0]  prot = 32'h0;
  logic [31:0]  pm [4];
  logic [31:0]  r;
  logic         hbusy = 1'b0;
  logic         rpend = 1'b0;
  int           miscompares = 0;
  int           cmp_count = 0;
  int           cyc = 0;
  int           i;

  // Host clock keeps running for the whole run
  always #20 CLK = ~CLK;

  pwp_bridge #(.N_PERIPH(32), .SLOT_LSB(10)) dut (
    .CLK(CLK), .RST_B(RST_B), .AHB_REQ(AHB_REQ), .HWDATA(HWDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
    .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_BE(REG_BE), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_ERR(REG_ERR),
    .GUARD_CLK_EN(GUARD_CLK_EN));

  pwp_periph_model periph (
    .clk(CLK), .rst_b(RST_B), .req(APB_REQ), .wait_cyc(wait_cyc),
    .err_en(err_en), .rsp(APB_RSP));

  function automatic logic [64:0] mk(input logic e, input logic [31:0] m,
                                     input logic [31:0] d);
    return {e, m, d};
  endfunction : mk

  task automatic check(input logic [64:0] e, input logic er,
                       input logic [31:0] d, input string nm);
    `CHK({nm, " error"}, e[64], er)
    `CHK({nm, " data"}, e[31:0], d & e[63:32])
  endtask : check

  // ------------------------------------------------------------
  // Result watcher: takes the oldest note when a result shows
  // ------------------------------------------------------------
  always @(negedge CLK) begin
    if (hbusy && HREADYOUT) begin
      check(hq.pop_front(), HRESP, HRDATA, "host");
      hbusy = 1'b0;
    end
    if (AHB_REQ.hsel && AHB_REQ.htrans[1] && HREADYOUT) hbusy = 1'b1;
    if (rpend) check(rq.pop_front(), REG_ERR, REG_RDATA, "reg");
    rpend = REG_RD || REG_WR;
  end

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      results();
    end
  end

  // ------------------------------------------------------------
  // Drivers: called just after a rising edge
  // ------------------------------------------------------------
  task automatic host(input logic wr, input logic [31:0] a,
                      input logic [2:0] sz, input logic [3:0] m,
                      input logic [31:0] d, input logic [64:0] e);
    hq.push_back(e);
    AHB_REQ.hsel <= 1'b1;
    AHB_REQ.htrans <= 2'b10;
    AHB_REQ.haddr <= a;
    AHB_REQ.hwrite <= wr;
    AHB_REQ.hsize <= sz;
    AHB_REQ.hmaster <= m;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    AHB_REQ.hsel <= 1'b0;
    AHB_REQ.htrans <= 2'b00;
    HWDATA <= wr ? d : 32'h0;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
  endtask : host

  // Strobe stays up so back to back accesses need no gap
  task automatic regop(input logic wr, input logic [3:0] a,
                       input logic [3:0] be, input logic [31:0] d,
                       input logic [64:0] e);
    rq.push_back(e);
    REG_WR <= wr;
    REG_RD <= !wr;
    REG_ADDR <= a;
    REG_BE <= be;
    REG_WDATA <= d;
    @(posedge CLK);
  endtask : regop

  task automatic reg_end;
    REG_WR <= 1'b0;
    REG_RD <= 1'b0;
    @(posedge CLK);
  endtask : reg_end

  task automatic pset(input logic set, input logic [3:0] be,
                      input logic [31:0] d);
    logic [31:0] k;
    k = d & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    regop(1'b1, set ? 4'h4 : 4'h0, be, d, mk(set ? |(prot & k) : |(~prot & k),
          32'hFFFF_FFFF, 32'h0));
    prot = set ? (prot | k) : (prot & ~k);
  endtask : pset

  initial begin
    AHB_REQ.hready = 1'b1;
    void'($urandom(32'h1f0e));
    repeat (4) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    #1;
    `CHK("guard clocks", 3'h3, GUARD_CLK_EN)
    `CHK("host ready", 1'b1, HREADYOUT)
    regop(1'b0, 4'h8, 4'hF, 32'h0, mk(1'b0, 32'h0000_0007, 32'h3));
    // Random set and clear traffic, each followed by a view read
    for (i = 0; i < 40; i++) begin
      pset(1'($urandom_range(0, 1)), 4'($urandom_range(0, 15)),
           i[0] ? $urandom : 32'h1 << $urandom_range(0, 31));
      regop(1'b0, i[1] ? 4'h4 : 4'h0, 4'hF, 32'h0,
            mk(1'b0, 32'hFFFF_FFFF, prot));
    end
    regop(1'b1, 4'h2, 4'hF, 32'hFFFF_FFFF, mk(1'b0, 32'hFFFF_FFFF, 32'h0));
    regop(1'b0, 4'h2, 4'hF, 32'h0, mk(1'b0, 32'hFFFF_FFFF, 32'h0));
    regop(1'b0, 4'h0, 4'hF, 32'h0, mk(1'b0, 32'hFFFF_FFFF, prot));
    pset(1'b0, 4'hF, 32'hFFFF_FFFF);
    reg_end();
    // Word write, byte merge, halfword and word reads with random waits
    for (i = 0; i < 4; i++) begin
      wait_cyc <= 2'($urandom_range(0, 3));
      r = $urandom;
      host(1'b1, i << 10, 3'h2, 4'h0, r, mk(1'b0, 32'h0, 32'h0));
      host(1'b1, (i << 10) + 1, 3'h0, 4'h0, 32'hA5A5_A5A5,
           mk(1'b0, 32'h0, 32'h0));
      pm[i] = {r[31:16], 8'hA5, r[7:0]};
      host(1'b0, (i << 10) + 2, 3'h1, 4'h0, 32'h0,
           mk(1'b0, 32'hFFFF_FFFF, {r[31:16], 16'h0}));
      host(1'b0, i << 10, 3'h2, 4'h0, 32'h0, mk(1'b0, 32'hFFFF_FFFF, pm[i]));
    end
    pset(1'b1, 4'hF, 32'h0000_0004);
    reg_end();
    host(1'b1, 2 << 10, 3'h2, 4'h0, 32'h1234_5678, mk(1'b1, 32'h0, 32'h0));
    host(1'b0, 2 << 10, 3'h2, 4'h0, 32'h0, mk(1'b0, 32'hFFFF_FFFF, pm[2]));
    regop(1'b0, 4'hC, 4'hF, 32'h0, mk(1'b0, 32'h8000_001F, 32'h8000_0002));
    reg_end();
    host(1'b1, 2 << 10, 3'h2, 4'h1, 32'hC0DE_F00D, mk(1'b0, 32'h0, 32'h0));
    host(1'b0, 2 << 10, 3'h2, 4'h0, 32'h0, mk(1'b0, 32'hFFFF_FFFF, 32'hC0DE_F00D));
    pset(1'b1, 4'hF, 32'h0000_0004);
    pset(1'b0, 4'hF, 32'h0000_0004);
    pset(1'b0, 4'hF, 32'h0000_0004);
    reg_end();
    host(1'b1, 2 << 10, 3'h2, 4'h0, 32'h600D_0002, mk(1'b0, 32'h0, 32'h0));
    host(1'b0, 2 << 10, 3'h2, 4'h0, 32'h0, mk(1'b0, 32'hFFFF_FFFF, 32'h600D_0002));
    err_en <= 1'b1;
    host(1'b1, 1 << 10, 3'h2, 4'h0, 32'h0, mk(1'b1, 32'h0, 32'h0));
    err_en <= 1'b0;
    regop(1'b1, 4'h8, 4'h1, 32'h0000_0007, mk(1'b0, 32'hFFFF_FFFF, 32'h0));
    reg_end();
    #1;
    `CHK("guard clocks", 3'h7, GUARD_CLK_EN)
    repeat (2) @(posedge CLK);
    results();
  end
endmodule : tb
`default_nettype wire
